// file: hw/gpio_port_pkg.sv
package gpio_port_pkg;

	////////////////////////////////////////////////////////////////////////
	// bus geometry
	localparam int unsigned DATA_W = 32;
	localparam int unsigned SEL_W = 4;
	localparam int unsigned PORT_LSB = 5;

	////////////////////////////////////////////////////////////////////////
	// register offsets inside one port window (byte addresses)
	localparam logic [4:0] OFF_INPUT = 5'h00;
	localparam logic [4:0] OFF_DIR = 5'h04;
	localparam logic [4:0] OFF_OUT = 5'h08;
	localparam logic [4:0] OFF_DIR_SET = 5'h0c;
	localparam logic [4:0] OFF_DIR_CLR = 5'h10;
	localparam logic [4:0] OFF_OUT_SET = 5'h14;
	localparam logic [4:0] OFF_OUT_CLR = 5'h18;

	////////////////////////////////////////////////////////////////////////
	// control register, shared by all ports
	localparam logic [11:0] CTRL_ADDR = 12'h400;
	localparam int unsigned PUD_BIT = 4;

	////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic RST_PUD = 1'b0;
	localparam logic RST_BIT = 1'b0;

	////////////////////////////////////////////////////////////////////////
	// read pipeline: answer one cycle after the request is seen
	localparam int unsigned ACK_LATENCY = 1;

endpackage

// file: hw/pin_sync.sv
`timescale 1ns/1ps

// half-cycle stage on the falling edge stands in for the transparent-high latch,
// the rising-edge stage is the input register itself
module pin_sync #(
	parameter int unsigned WIDTH = 8
) (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	// raw pins and synchronised copy
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] latch_reg;
	logic [WIDTH-1:0] sample_reg;

	// capture on the falling edge, read only by the next stage
	always_ff @(negedge clk_sys_in) begin
		if (!nrst_in) begin
			latch_reg <= '0;
		end else begin
			latch_reg <= async_in;
		end
	end

	// input register on the following rising edge
	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			sample_reg <= '0;
		end else begin
			sample_reg <= latch_reg;
		end
	end

	assign sync_out = sample_reg;

endmodule

// file: hw/bidirectional_port_pins.sv
`timescale 1ns/1ps

module bidirectional_port_pins
	import gpio_port_pkg::*;
#(
	parameter int unsigned NUM_PORTS = 3,
	parameter int unsigned PORT_WIDTH = 8,
	parameter int unsigned ADDR_W = 12
) (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	// wishbone classic slave
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [ADDR_W-1:0] wb_adr_in,
	input wire logic [SEL_W-1:0] wb_sel_in,
	input wire logic [DATA_W-1:0] wb_dat_in,
	output logic [DATA_W-1:0] wb_dat_out,
	output logic wb_ack_out,
	// pins, flattened port by port, pin 0 of port 0 in bit 0
	input wire logic [NUM_PORTS*PORT_WIDTH-1:0] pin_in,
	output logic [NUM_PORTS*PORT_WIDTH-1:0] pin_out,
	output logic [NUM_PORTS*PORT_WIDTH-1:0] pin_oe_out,
	output logic [NUM_PORTS*PORT_WIDTH-1:0] pin_pullup_out,
	// alternate function overrides, one bit per pin
	input wire logic [NUM_PORTS*PORT_WIDTH-1:0] alt_override_in,
	input wire logic [NUM_PORTS*PORT_WIDTH-1:0] alt_oe_in,
	input wire logic [NUM_PORTS*PORT_WIDTH-1:0] alt_value_in
);

	localparam int unsigned PIN_COUNT = NUM_PORTS * PORT_WIDTH;
	localparam int unsigned PIDX_W = ADDR_W - PORT_LSB;

	////////////////////////////////////////////////////////////////////////
	// decode helpers

	// true when the address hits a given register of a given port
	function automatic logic port_hit(
		input logic [ADDR_W-1:0] addr,
		input int unsigned port,
		input logic [4:0] off
	);
		logic idx_ok;
		idx_ok = (addr[ADDR_W-1:PORT_LSB] == PIDX_W'(port));
		return idx_ok && (addr[PORT_LSB-1:0] == off);
	endfunction

	// true when the address hits the shared control register
	function automatic logic ctrl_hit(input logic [ADDR_W-1:0] addr);
		return addr == ADDR_W'(CTRL_ADDR);
	endfunction

	// next value of a port register for one write strobe
	function automatic logic [PORT_WIDTH-1:0] apply_write(
		input logic [PORT_WIDTH-1:0] cur,
		input logic [PORT_WIDTH-1:0] wdata,
		input logic plain,
		input logic set,
		input logic clr,
		input logic tgl
	);
		logic [PORT_WIDTH-1:0] res;
		res = cur;
		if (plain) begin
			res = wdata;
		end else if (set) begin
			res = cur | wdata;
		end else if (clr) begin
			res = cur & ~wdata;
		end else if (tgl) begin
			res = cur ^ wdata;
		end
		return res;
	endfunction

	// pull-up wanted: input pin, data one, not globally disabled
	function automatic logic [PIN_COUNT-1:0] pull_enable(
		input logic [PIN_COUNT-1:0] dir,
		input logic [PIN_COUNT-1:0] dat,
		input logic disable_all
	);
		return ~dir & dat & {PIN_COUNT{!disable_all}};
	endfunction

	// control register image: only the pull-up disable bit is kept
	function automatic logic [DATA_W-1:0] ctrl_view(input logic disable_all);
		logic [DATA_W-1:0] img;
		img = '0;
		img[PUD_BIT] = disable_all;
		return img;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// state

	logic [PORT_WIDTH-1:0] dir_reg [NUM_PORTS];
	logic [PORT_WIDTH-1:0] out_reg [NUM_PORTS];
	logic pud_reg;
	logic ack_reg;
	logic [DATA_W-1:0] rdat_reg;
	logic [DATA_W-1:0] rdat_next;
	logic [PIN_COUNT-1:0] pin_sync;
	logic req;
	logic req_new;
	logic wr_fire;
	logic [PORT_WIDTH-1:0] wdata;
	logic [PORT_WIDTH-1:0] dir_next [NUM_PORTS];
	logic [PORT_WIDTH-1:0] out_next [NUM_PORTS];
	logic pud_next;
	// one-hot register hits per port
	logic [NUM_PORTS-1:0] hit_input;
	logic [NUM_PORTS-1:0] hit_dir;
	logic [NUM_PORTS-1:0] hit_dir_set;
	logic [NUM_PORTS-1:0] hit_dir_clr;
	logic [NUM_PORTS-1:0] hit_out;
	logic [NUM_PORTS-1:0] hit_out_set;
	logic [NUM_PORTS-1:0] hit_out_clr;
	logic hit_ctrl;
	// per-pin views of the port registers
	logic [PIN_COUNT-1:0] dir_flat;
	logic [PIN_COUNT-1:0] out_flat;
	logic [PIN_COUNT-1:0] gpio_oe;
	logic [PIN_COUNT-1:0] gpio_pullup;

	////////////////////////////////////////////////////////////////////////
	// bus handshake

	// a request is live while cyc and stb are both high
	assign req = wb_cyc_in && wb_stb_in;

	// first cycle of a request, before ack answers it
	assign req_new = req && !ack_reg;

	// ack rises one cycle after the request and drops after one cycle
	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= req_new;
		end
	end

	assign wb_ack_out = ack_reg;

	// writes land on the edge that the master sees ack; data in byte lane 0
	assign wr_fire = req && ack_reg && wb_we_in && wb_sel_in[0];
	assign wdata = wb_dat_in[PORT_WIDTH-1:0];

	////////////////////////////////////////////////////////////////////////
	// input synchroniser

	pin_sync #(
		.WIDTH(PIN_COUNT)
	) u_pin_sync (
		.clk_sys_in(clk_sys_in),
		.nrst_in(nrst_in),
		.async_in(pin_in),
		.sync_out(pin_sync)
	);

	////////////////////////////////////////////////////////////////////////
	// address decode

	// one hit per register kind and port, shared by write and read paths
	always_comb begin
		hit_input = '0;
		hit_dir = '0;
		hit_dir_set = '0;
		hit_dir_clr = '0;
		hit_out = '0;
		hit_out_set = '0;
		hit_out_clr = '0;
		for (int unsigned p = 0; p < NUM_PORTS; p++) begin
			hit_input[p] = port_hit(wb_adr_in, p, OFF_INPUT);
			hit_dir[p] = port_hit(wb_adr_in, p, OFF_DIR);
			hit_dir_set[p] = port_hit(wb_adr_in, p, OFF_DIR_SET);
			hit_dir_clr[p] = port_hit(wb_adr_in, p, OFF_DIR_CLR);
			hit_out[p] = port_hit(wb_adr_in, p, OFF_OUT);
			hit_out_set[p] = port_hit(wb_adr_in, p, OFF_OUT_SET);
			hit_out_clr[p] = port_hit(wb_adr_in, p, OFF_OUT_CLR);
		end
	end

	// the control register sits outside every port window
	assign hit_ctrl = ctrl_hit(wb_adr_in);

	////////////////////////////////////////////////////////////////////////
	// direction registers

	// full write, set-mask and clear-mask aliases; other bits stay put
	always_comb begin
		for (int unsigned p = 0; p < NUM_PORTS; p++) begin
			dir_next[p] = dir_reg[p];
			if (wr_fire) begin
				dir_next[p] = apply_write(dir_reg[p], wdata, hit_dir[p],
					hit_dir_set[p], hit_dir_clr[p], 1'b0);
			end
		end
	end

	// reset to input on every pin
	always_ff @(posedge clk_sys_in) begin
		for (int unsigned p = 0; p < NUM_PORTS; p++) begin
			if (!nrst_in) begin
				dir_reg[p] <= {PORT_WIDTH{RST_BIT}};
			end else begin
				dir_reg[p] <= dir_next[p];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// output data registers

	// writes of ones to the input address toggle data, any direction
	always_comb begin
		for (int unsigned p = 0; p < NUM_PORTS; p++) begin
			out_next[p] = out_reg[p];
			if (wr_fire) begin
				out_next[p] = apply_write(out_reg[p], wdata, hit_out[p],
					hit_out_set[p], hit_out_clr[p],
					hit_input[p]);
			end
		end
	end

	// reset to zero, so no drive level and no pull-up after reset
	always_ff @(posedge clk_sys_in) begin
		for (int unsigned p = 0; p < NUM_PORTS; p++) begin
			if (!nrst_in) begin
				out_reg[p] <= {PORT_WIDTH{RST_BIT}};
			end else begin
				out_reg[p] <= out_next[p];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control register

	// global pull-up disable, shared by every port
	assign pud_next = (wr_fire && hit_ctrl) ? wdata[PUD_BIT] : pud_reg;

	// pull-ups allowed again after reset
	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			pud_reg <= RST_PUD;
		end else begin
			pud_reg <= pud_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read data

	// unmapped addresses read as zero; set/clear aliases read the register
	always_comb begin
		rdat_next = '0;
		for (int unsigned p = 0; p < NUM_PORTS; p++) begin
			if (hit_input[p]) begin
				rdat_next[PORT_WIDTH-1:0] = pin_sync[p*PORT_WIDTH +: PORT_WIDTH];
			end
			if (hit_dir[p] || hit_dir_set[p] || hit_dir_clr[p]) begin
				rdat_next[PORT_WIDTH-1:0] = dir_reg[p];
			end
			if (hit_out[p] || hit_out_set[p] || hit_out_clr[p]) begin
				rdat_next[PORT_WIDTH-1:0] = out_reg[p];
			end
		end
		if (hit_ctrl) begin
			rdat_next = ctrl_view(pud_reg);
		end
	end

	// read data is caught as ack rises and held for that cycle
	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			rdat_reg <= '0;
		end else if (req_new) begin
			rdat_reg <= rdat_next;
		end
	end

	assign wb_dat_out = rdat_reg;

	////////////////////////////////////////////////////////////////////////
	// pin drivers

	// registers laid out pin by pin, port 0 in the low bits
	always_comb begin
		dir_flat = '0;
		out_flat = '0;
		for (int unsigned p = 0; p < NUM_PORTS; p++) begin
			dir_flat[p*PORT_WIDTH +: PORT_WIDTH] = dir_reg[p];
			out_flat[p*PORT_WIDTH +: PORT_WIDTH] = out_reg[p];
		end
	end

	// output enable follows direction; reset drops it at once, no clock needed
	always_comb begin
		gpio_oe = '0;
		if (nrst_in) begin
			gpio_oe = dir_flat;
		end
	end

	// pull-up only for input with data one, unless globally disabled
	always_comb begin
		gpio_pullup = '0;
		if (nrst_in) begin
			gpio_pullup = pull_enable(dir_flat, out_flat, pud_reg);
		end
	end

	// per-pin override only touches its own pin
	always_comb begin
		pin_oe_out = '0;
		pin_out = '0;
		pin_pullup_out = '0;
		for (int unsigned i = 0; i < PIN_COUNT; i++) begin
			if (alt_override_in[i]) begin
				pin_oe_out[i] = nrst_in && alt_oe_in[i];
				pin_out[i] = alt_value_in[i];
				pin_pullup_out[i] = 1'b0;
			end else begin
				pin_oe_out[i] = gpio_oe[i];
				pin_out[i] = out_flat[i];
				pin_pullup_out[i] = gpio_pullup[i];
			end
		end
	end

endmodule

// file: sim/gpio_port_sva.sv
`timescale 1ns/1ps
// watches the bus, the toggle, direction-set and direction-clear writes of port 0 and the pin controls of every port
module gpio_port_sva
	import gpio_port_pkg::*;
#(
	parameter int unsigned NUM_PORTS = 3,
	parameter int unsigned PORT_WIDTH = 8,
	parameter int unsigned ADDR_W = 12
) (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	// bus
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [ADDR_W-1:0] wb_adr_in,
	input wire logic [SEL_W-1:0] wb_sel_in,
	input wire logic [DATA_W-1:0] wb_dat_in,
	input wire logic wb_ack_out,
	// pins
	input wire logic [NUM_PORTS*PORT_WIDTH-1:0] pin_out,
	input wire logic [NUM_PORTS*PORT_WIDTH-1:0] pin_oe_out,
	input wire logic [NUM_PORTS*PORT_WIDTH-1:0] pin_pullup_out,
	input wire logic [NUM_PORTS*PORT_WIDTH-1:0] alt_override_in,
	input wire logic [NUM_PORTS*PORT_WIDTH-1:0] alt_oe_in
);
	logic pud_reg;
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!nrst_in);
	// shadow of the global pull-up disable bit
	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in)
			pud_reg <= 1'b0;
		else if (wb_ack_out && wb_we_in && wb_sel_in[0] && wb_adr_in == ADDR_W'(CTRL_ADDR))
			pud_reg <= wb_dat_in[PUD_BIT];
	end
	// committed write to a port-0 offset, no override around it
	sequence s_wr(logic [4:0] off);
		wb_ack_out && wb_we_in && wb_sel_in[0] && wb_adr_in == ADDR_W'(off)
			&& alt_override_in == '0 ##1 alt_override_in == '0;
	endsequence
	a_ack_next: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
		else $error("ack late");
	a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
		else $error("ack too long");
	a_toggle_data: assert property (s_wr(OFF_INPUT) |->
		pin_out[7:0] == ($past(pin_out[7:0]) ^ $past(wb_dat_in[7:0])))
		else $error("toggle wrong");
	a_dir_set: assert property (s_wr(OFF_DIR_SET) |->
		pin_oe_out[7:0] == ($past(pin_oe_out[7:0]) | $past(wb_dat_in[7:0])))
		else $error("set disturbed");
	a_dir_clear: assert property (s_wr(OFF_DIR_CLR) |->
		pin_oe_out[7:0] == ($past(pin_oe_out[7:0]) & ~$past(wb_dat_in[7:0])))
		else $error("clear disturbed");
	a_pull_rule: assert property ((pin_pullup_out & ~alt_override_in) == (~pin_oe_out
		& pin_out & ~alt_override_in & {(NUM_PORTS*PORT_WIDTH){!pud_reg}}))
		else $error("pull-up wrong");
	a_pud_off: assert property (pud_reg |-> pin_pullup_out == '0)
		else $error("pull-up not off");
	a_alt_keep: assert property ((pin_oe_out & alt_override_in) == (alt_oe_in & alt_override_in))
		else $error("override enable wrong");
endmodule
bind bidirectional_port_pins gpio_port_sva #(.NUM_PORTS(NUM_PORTS), .PORT_WIDTH(PORT_WIDTH),
	.ADDR_W(ADDR_W)) u_sva (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .wb_cyc_in(wb_cyc_in),
	.wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in),
	.wb_dat_in(wb_dat_in), .wb_ack_out(wb_ack_out), .pin_out(pin_out), .pin_oe_out(pin_oe_out),
	.pin_pullup_out(pin_pullup_out), .alt_override_in(alt_override_in), .alt_oe_in(alt_oe_in));

// file: sim/pin_board.sv
`timescale 1ns/1ps
// pads with board drivers; a pad nobody holds wanders
module pin_board (
	// clock
	input wire logic clk_sys_in,
	// pad controls from the port and the board
	input wire logic [7:0] drv_in,
	input wire logic [7:0] oe_in,
	input wire logic [7:0] pu_in,
	input wire logic [7:0] ext_en_in,
	input wire logic [7:0] ext_in,
	// resolved pad level
	output logic [7:0] lvl_out
);
	logic [7:0] flt_reg = 8'h00;
	// floating pads flip every cycle
	always_ff @(posedge clk_sys_in) begin
		flt_reg <= ~flt_reg;
	end
	// port driver wins, then board, then pull-up
	assign lvl_out = (oe_in & drv_in) | (~oe_in & ext_en_in & ext_in)
		| (~oe_in & ~ext_en_in & (pu_in | flt_reg));
endmodule

// file: sim/bidirectional_port_pins_test.sv
`timescale 1ns/1ps
module bidirectional_port_pins_test;
	import gpio_port_pkg::*;
	logic clk_sys_in = 1'b0;
	logic nrst_in = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [11:0] adr = 12'h000;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic ack;
	logic [7:0] pin_in, pin_out, oe, pu, d, o, r, v;
	logic [7:0] alt_ov = 8'h00;
	logic [7:0] alt_oe = 8'h00;
	logic [7:0] alt_val = 8'h00;
	logic [7:0] ext_en = 8'h00;
	logic [7:0] ext = 8'h00;
	logic global_pullup_disable;
	logic [31:0] seed = 32'hb272;
	int errors = 0;
	int check_count = 0;
	logic [11:0] offs [8] = '{12'(OFF_INPUT), 12'(OFF_DIR), 12'(OFF_OUT), 12'(OFF_DIR_SET),
		12'(OFF_DIR_CLR), 12'(OFF_OUT_SET), 12'(OFF_OUT_CLR), CTRL_ADDR};
	bidirectional_port_pins #(.NUM_PORTS(1)) u_dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
		.wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
		.wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe_out(oe), .pin_pullup_out(pu), .alt_override_in(alt_ov),
		.alt_oe_in(alt_oe), .alt_value_in(alt_val));
	pin_board u_board (.clk_sys_in(clk_sys_in), .drv_in(pin_out), .oe_in(oe), .pu_in(pu),
		.ext_en_in(ext_en), .ext_in(ext), .lvl_out(pin_in));
	// clock
	initial begin
		forever #5 clk_sys_in = ~clk_sys_in;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// expected pull-up vector
	function automatic logic [7:0] pull(input logic [7:0] dd, input logic [7:0] oo, input logic p);
		return ~dd & oo & {8{~p}};
	endfunction
	task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
		check_count++;
		if (s !== e) begin
			errors++;
			$display("[ERR] %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// one classic cycle, read data left in r
	task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] dv);
		int n;
		@(posedge clk_sys_in);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hf;
		wdat <= {24'h0, dv};
		n = 0;
		do begin
			@(posedge clk_sys_in);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (n >= 20) begin
			errors++;
			wrap_up();
		end
		r = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	// main sequence
	initial begin
		repeat (5) @(posedge clk_sys_in);
		chk("oe rst", oe, 8'h00);
		chk("pu rst", pu, 8'h00);
		nrst_in <= 1'b1;
		ext_en <= 8'hff;
		d = 8'h00;
		o = 8'h00;
		global_pullup_disable = 1'b0;
		for (int i = 0; i < 60; i++) begin
			seed = lfsr(seed);
			v = seed[15:8];
			ext <= seed[23:16];
			wb(1'b1, offs[seed[2:0]], v);
			case (seed[2:0])
				3'd0: o = o ^ v;
				3'd1: d = v;
				3'd2: o = v;
				3'd3: d = d | v;
				3'd4: d = d & ~v;
				3'd5: o = o | v;
				3'd6: o = o & ~v;
				default: global_pullup_disable = v[PUD_BIT];
			endcase
			@(posedge clk_sys_in);
			wb(1'b0, offs[0], 8'h00);
			chk("input", r, (d & o) | (~d & seed[23:16]));
			wb(1'b0, offs[1], 8'h00);
			chk("dir", r, d);
			wb(1'b0, offs[2], 8'h00);
			chk("data", r, o);
			chk("oe", oe, d);
			chk("drive", pin_out, o);
			chk("pullup", pu, pull(d, o, global_pullup_disable));
		end
		wb(1'b0, 12'h3fc, 8'h00);
		chk("unmapped", r, 8'h00);
		alt_ov <= 8'h0f;
		alt_oe <= 8'h05;
		alt_val <= 8'h0a;
		repeat (2) @(posedge clk_sys_in);
		chk("alt oe", oe, {d[7:4], 4'h5});
		chk("alt drive", pin_out, {o[7:4], 4'ha});
		chk("alt pullup", pu, pull(d, o, global_pullup_disable) & 8'hf0);
		alt_ov <= 8'h00;
		// pull-up kill, then input-pull-up to output-low through tri-state
		wb(1'b1, offs[7], 8'h10);
		wb(1'b0, offs[7], 8'h00);
		chk("ctrl", r, 8'h10);
		wb(1'b1, offs[1], 8'h00);
		wb(1'b1, offs[2], 8'h01);
		@(posedge clk_sys_in);
		chk("pud glitch", pu, 8'h00);
		wb(1'b1, offs[7], 8'h00);
		@(posedge clk_sys_in);
		chk("pull on", pu, 8'h01);
		wb(1'b1, offs[6], 8'h01);
		@(posedge clk_sys_in);
		chk("tri oe", oe, 8'h00);
		chk("tri pull", pu, 8'h00);
		wb(1'b1, offs[3], 8'h01);
		@(posedge clk_sys_in);
		chk("low oe", oe, 8'h01);
		chk("low drive", pin_out, 8'h00);
		wb(1'b1, offs[1], 8'hff);
		nrst_in <= 1'b0;
		#1;
		chk("oe async", oe, 8'h00);
		repeat (5) @(posedge clk_sys_in);
		nrst_in <= 1'b1;
		wb(1'b0, offs[1], 8'h00);
		chk("dir rst", r, 8'h00);
		wrap_up();
	end
endmodule
